// [sla_expander.sv]
/*
 Serial-loaded 20-bit address expander with three chip selects.
 Assumes serial pins are asynchronous and ref_clk is much faster than the serial clock.
*/
`timescale 1ns/1ps
module sla_expander (
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rst_b,
    input  wire logic                       clk_en,
    // Serial pins
    input  wire logic                       chip_enable_n,
    input  wire logic                       serial_clock_in,
    input  wire logic                       serial_param_in,
    input  wire logic                       select_output_disable,
    // Outputs
    output logic [sla_pkg::CNT_W-1:0]       counter_out,
    output logic [sla_pkg::NUM_SEL-1:0]     mem_select_n
);
    ////////////////////////////////////////////////////////////////////////////
    logic ce_n_s;
    logic sck_s;
    logic din_s;
    logic oe_dis_s;

    sla_sync u_sync_ce  (.clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
                         .async_in(chip_enable_n), .sync_out(ce_n_s));
    sla_sync u_sync_sck (.clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
                         .async_in(serial_clock_in), .sync_out(sck_s));
    sla_sync u_sync_din (.clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
                         .async_in(serial_param_in), .sync_out(din_s));
    sla_sync u_sync_oe  (.clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
                         .async_in(select_output_disable), .sync_out(oe_dis_s));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] sel_decode(input logic lo, input logic hi);
        // 11 folds back to output 0
        sel_decode = (hi && !lo) ? 2'h2 : ((lo && !hi) ? 2'h1 : 2'h0);
    endfunction : sel_decode

    function automatic logic [1:0] sel_next(input logic [1:0] cur);
        sel_next = (cur == 2'h2) ? 2'h0 : cur + 2'h1;
    endfunction : sel_next

    sla_pkg::sla_state_t          state_r;
    sla_pkg::sla_state_t          state_nxt;
    logic                         sck_d_r;
    logic                         ce_d_r;
    logic [5:0]                   pulse_r;
    logic [sla_pkg::CNT_W-1:0]    shift_r;
    logic [sla_pkg::CNT_W-1:0]    cnt_r;
    logic                         s_lo_r;
    logic                         s_hi_r;
    logic                         m_lo_r;
    logic                         m_hi_r;
    logic [1:0]                   sel_r;
    logic                         sel_act_r;

    wire        sck_fall  = sck_d_r && !sck_s;
    wire        ce_fall   = ce_d_r && !ce_n_s;
    wire [5:0]  pulse_now = pulse_r + 6'h01;
    wire [4:0]  msb_idx   = sla_pkg::MSB_1MB + {3'h0, m_hi_r, m_lo_r};
    wire [sla_pkg::CNT_W-1:0] cnt_inc = cnt_r + 20'h00001;
    wire        msb_drop  = cnt_r[msb_idx] && !cnt_inc[msb_idx];
    wire        load_fall = (state_r == sla_pkg::SLA_LOAD) && sck_fall;
    wire [sla_pkg::CNT_W-1:0] init_val =
        {shift_r[sla_pkg::CNT_W-1:sla_pkg::OFFSET_W], {sla_pkg::OFFSET_W{1'b0}}};

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sla_pkg::SLA_IDLE: if (ce_fall) state_nxt = sla_pkg::SLA_LOAD;
            sla_pkg::SLA_LOAD: if (load_fall && pulse_now == sla_pkg::PULSE_FRAME)
                                   state_nxt = sla_pkg::SLA_RUN;
            sla_pkg::SLA_RUN:  state_nxt = state_r;
        endcase
        if (ce_n_s) state_nxt = sla_pkg::SLA_IDLE;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= sla_pkg::SLA_IDLE;
            sck_d_r <= 1'b0;
            // Synced pin also leaves reset low, so a high here would fake a fall
            ce_d_r  <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            sck_d_r <= sck_s;
            ce_d_r  <= ce_n_s;
        end
    end

    // Frame loading
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_r <= 6'h00;
            shift_r <= '0;
            s_lo_r  <= 1'b0;
            s_hi_r  <= 1'b0;
            m_lo_r  <= 1'b0;
            m_hi_r  <= 1'b0;
        end else if (clk_en) begin
            if (state_r != sla_pkg::SLA_LOAD) begin
                pulse_r <= 6'h00;
            end else if (load_fall) begin
                pulse_r <= pulse_now;
                if (pulse_now <= sla_pkg::PULSE_INIT_LAST)
                    shift_r[pulse_r[4:0]] <= din_s;
                if (pulse_now == sla_pkg::PULSE_SEL_LO) s_lo_r <= din_s;
                if (pulse_now == sla_pkg::PULSE_SEL_HI) s_hi_r <= din_s;
                if (pulse_now == sla_pkg::PULSE_MEM_LO) m_lo_r <= din_s;
                if (pulse_now == sla_pkg::PULSE_MEM_HI) m_hi_r <= din_s;
                // Later pulses carry no data
            end
        end
    end

    // Counter and chip select
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r     <= '0;
            sel_r     <= 2'h0;
            sel_act_r <= 1'b0;
        end else if (clk_en) begin
            if (ce_n_s) begin
                cnt_r     <= '0;
                sel_act_r <= 1'b0;
            end else if (load_fall && pulse_now == sla_pkg::PULSE_APPLY) begin
                cnt_r     <= init_val;
                sel_r     <= sel_decode(s_lo_r, s_hi_r);
                sel_act_r <= 1'b1;
            end else if (state_r == sla_pkg::SLA_RUN && sck_fall) begin
                cnt_r <= cnt_inc;
                if (msb_drop) sel_r <= sel_next(sel_r);
            end
        end
    end

    wire [2:0] sel_onehot_n = ~(3'h1 << sel_r);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_select_n <= sla_pkg::SEL_ALL_OFF;
        end else if (clk_en) begin
            mem_select_n <= (oe_dis_s || !sel_act_r || ce_n_s) ?
                            sla_pkg::SEL_ALL_OFF : sel_onehot_n;
        end
    end

    assign counter_out = cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    property p_idle_zero;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && ce_n_s) |=> (cnt_r == '0);
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("counter not cleared");

    property p_run_inc;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && !ce_n_s && state_r == sla_pkg::SLA_RUN && sck_fall)
            |=> (cnt_r == $past(cnt_r) + 20'h00001);
    endproperty
    a_run_inc: assert property (p_run_inc) else $error("counter did not advance");

    property p_offset_zero;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && !ce_n_s && load_fall && pulse_now == sla_pkg::PULSE_APPLY)
            |=> (cnt_r[sla_pkg::OFFSET_W-1:0] == '0);
    endproperty
    a_offset_zero: assert property (p_offset_zero) else $error("offset not zero");

    property p_disable;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && oe_dis_s) |=> (mem_select_n == sla_pkg::SEL_ALL_OFF);
    endproperty
    a_disable: assert property (p_disable) else $error("select not disabled");

    property p_one_low;
        @(posedge ref_clk) disable iff (!rst_b)
        1'b1 |-> $countones(~mem_select_n) <= 1;
    endproperty
    a_one_low: assert property (p_one_low) else $error("several selects low");

    property p_sel_code;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && !ce_n_s && load_fall && pulse_now == sla_pkg::PULSE_APPLY && s_hi_r && s_lo_r)
            |=> (sel_r == 2'h0);
    endproperty
    a_sel_code: assert property (p_sel_code) else $error("code 11 wrong");

    property p_sel_move;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && !ce_n_s && state_r == sla_pkg::SLA_RUN && sck_fall && msb_drop)
            |=> (sel_r != $past(sel_r));
    endproperty
    a_sel_move: assert property (p_sel_move) else $error("select did not move");

    property p_sel_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        (state_r == sla_pkg::SLA_RUN && !sck_fall) |=> $stable(sel_r);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select changed idle");

    property p_start;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && ce_fall && !ce_n_s && state_r == sla_pkg::SLA_IDLE)
            |=> (state_r == sla_pkg::SLA_LOAD);
    endproperty
    a_start: assert property (p_start) else $error("load not started");

    c_run:     cover property (@(posedge ref_clk) state_r == sla_pkg::SLA_RUN);
    c_move:    cover property (@(posedge ref_clk) state_r == sla_pkg::SLA_RUN && msb_drop);
    c_sel_low: cover property (@(posedge ref_clk) mem_select_n != sla_pkg::SEL_ALL_OFF);
endmodule : sla_expander

// [sla_pkg.sv]
/*
 Shared constants for the serial-loaded address expander.
 Assumes a single system clock that samples the serial pins.
*/
package sla_pkg;
    localparam int          CNT_W         = 20;
    localparam int          OFFSET_W      = 10;
    localparam int          NUM_SEL       = 3;
    localparam logic [5:0]  PULSE_INIT_LAST = 6'h14;
    localparam logic [5:0]  PULSE_SEL_LO  = 6'h15;
    localparam logic [5:0]  PULSE_SEL_HI  = 6'h16;
    localparam logic [5:0]  PULSE_MEM_LO  = 6'h17;
    localparam logic [5:0]  PULSE_MEM_HI  = 6'h18;
    localparam logic [5:0]  PULSE_APPLY   = 6'h19;
    localparam logic [5:0]  PULSE_FRAME   = 6'h20;
    localparam logic [4:0]  MSB_1MB       = 5'h10;
    localparam logic [2:0]  SEL_ALL_OFF   = 3'h7;

    typedef enum logic [2:0] {
        SLA_IDLE = 3'b001,
        SLA_LOAD = 3'b010,
        SLA_RUN  = 3'b100
    } sla_state_t;
endpackage : sla_pkg

// [sla_sync.sv]
/*
 Three-flop input synchroniser with agreement filter.
 Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module sla_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    // Data
    input  wire logic async_in,
    output logic      sync_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Only s2 and s3 are compared; s1 may be metastable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r     <= 1'b0;
            s2_r     <= 1'b0;
            s3_r     <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en) begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                sync_out <= s3_r;
            end
        end
    end
endmodule : sla_sync

// [sla_host.sv]
/*
 Host model for the address expander: drives chip enable, serial clock and data.
 Assumes ref_clk is the bench clock; each serial clock level lasts 8 ref_clk cycles.
*/
`timescale 1ns/1ps
module sla_host (
    // Clock
    input  wire logic ref_clk,
    // Serial pins
    output logic      chip_enable_n,
    output logic      serial_clock_in,
    output logic      serial_param_in
);
    initial begin
        chip_enable_n   = 1'b1;
        serial_clock_in = 1'b1;
        serial_param_in = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : hold

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock idles high outside frames, so no stray fall reaches the block
    task automatic open_frame();
        chip_enable_n <= 1'b0;
        hold(8);
    endtask : open_frame

    // Data stays put across the fall; afterwards it is inverted, not left stale
    task automatic pulse(input logic d);
        serial_param_in <= d;
        hold(4);
        serial_clock_in <= 1'b0;
        hold(8);
        serial_clock_in <= 1'b1;
        serial_param_in <= ~d;
        hold(4);
    endtask : pulse

    task automatic close_frame();
        chip_enable_n <= 1'b1;
        hold(8);
    endtask : close_frame
endmodule : sla_host

// [tb_top.sv]
/*
 Self-checking bench for the address expander with a host model on the pins.
 Assumes the design settles within 8 ref_clk cycles of any pin edge.
*/
`timescale 1ns/1ps
module tb_top;
    logic                        ref_clk;
    logic                        rst_b;
    logic                        select_output_disable;
    logic                        clk_en;
    logic                        chip_enable_n;
    logic                        serial_clock_in;
    logic                        serial_param_in;
    logic [sla_pkg::CNT_W-1:0]   counter_out;
    logic [sla_pkg::NUM_SEL-1:0] mem_select_n;
    logic [19:0]                 init_v;
    logic [19:0]                 base;
    logic [1:0]                  sc;
    logic [1:0]                  mc;
    int                          n_mismatch = 0;
    int                          checks = 0;
    int                          k;

    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    sla_host host (.ref_clk(ref_clk), .chip_enable_n(chip_enable_n),
        .serial_clock_in(serial_clock_in), .serial_param_in(serial_param_in));

    sla_expander DUT (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
        .chip_enable_n(chip_enable_n), .serial_clock_in(serial_clock_in),
        .serial_param_in(serial_param_in), .select_output_disable(select_output_disable),
        .counter_out(counter_out), .mem_select_n(mem_select_n));

    ////////////////////////////////////////////////////////////////////////////
    function automatic int idx_of(input logic [1:0] c);
        return (c == 2'h1) ? 1 : (c == 2'h2) ? 2 : 0;
    endfunction : idx_of

    function automatic logic [19:0] sel_of(input int i);
        return {17'h0, ~(3'h1 << i)};
    endfunction : sel_of

    task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        select_output_disable = 1'b0;
        clk_en = 1'b1;
        k = $urandom(15);
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("counter_out", counter_out, 20'h0);
        chk("mem_select_n", 20'(mem_select_n), 20'h7);
        for (int f = 0; f < 4; f++) begin
            sc = 2'(f);
            mc = 2'(3 - f);
            k = idx_of(sc);
            init_v = 20'($urandom);
            // Bits up to the size MSB set, so 1024 increments carry past it
            for (int b = 10; b <= 16 + int'(mc); b++)
                init_v[b] = 1'b1;
            base = {init_v[19:10], 10'h0};
            host.open_frame();
            for (int n = 0; n < 20; n++)
                host.pulse(init_v[n]);
            host.pulse(sc[0]);
            host.pulse(sc[1]);
            host.pulse(mc[0]);
            host.pulse(mc[1]);
            chk("counter_out", counter_out, 20'h0);
            chk("mem_select_n", 20'(mem_select_n), 20'h7);
            host.pulse(1'($urandom));
            chk("counter_out", counter_out, base);
            chk("mem_select_n", 20'(mem_select_n), sel_of(k));
            select_output_disable <= 1'b1;
            repeat (8) @(posedge ref_clk);
            chk("mem_select_n", 20'(mem_select_n), 20'h7);
            select_output_disable <= 1'b0;
            repeat (8) @(posedge ref_clk);
            chk("mem_select_n", 20'(mem_select_n), sel_of(k));
            for (int n = 26; n <= 32; n++)
                host.pulse(1'($urandom));
            chk("counter_out", counter_out, base);
            for (int j = 1; j <= 1024; j++) begin
                host.pulse(1'($urandom));
                if (j == 1)
                    chk("counter_out", counter_out, base + 20'h1);
                if (j == 1023)
                    chk("mem_select_n", 20'(mem_select_n), sel_of(k));
            end
            chk("counter_out", counter_out, base + 20'h400);
            chk("mem_select_n", 20'(mem_select_n), sel_of((k + 1) % 3));
            // Frozen for a whole pulse: the fall is never seen
            clk_en <= 1'b0;
            host.pulse(1'b0);
            clk_en <= 1'b1;
            repeat (8) @(posedge ref_clk);
            chk("counter_out", counter_out, base + 20'h400);
            host.close_frame();
            chk("counter_out", counter_out, 20'h0);
            chk("mem_select_n", 20'(mem_select_n), 20'h7);
            host.pulse(1'b1);
            chk("counter_out", counter_out, 20'h0);
        end
        give_verdict();
    end

    // Four frames of about 1060 pulses at 16 cycles each fit well inside this
    initial begin
        repeat (90000) @(posedge ref_clk);
        n_mismatch++;
        $display("FAIL watchdog expected finish seen hang");
        give_verdict();
    end
endmodule : tb_top
